/* common/rpd_defs.vh */
// Purpose : constants for the r port drive and pin function select block
// Assumes : 10-bit data memory address, 4-bit data
// Notes   : included by bare name
`ifndef RPD_DEFS_VH
`define RPD_DEFS_VH

// ****************************************************************
// widths and counts
// ****************************************************************
`define RPD_ADDR_W       10
`define RPD_DATA_W       4
`define RPD_GRP_W        4
`define RPD_GROUPS       9
`define RPD_PINS         36
`define RPD_D_PINS       12
`define RPD_AN_PINS      6

// ****************************************************************
// memory-mapped register addresses
// ****************************************************************
`define RPD_ADR_PM0      10'h008
`define RPD_ADR_PM_WAKE  10'h009
`define RPD_ADR_PM_EVT   10'h00a
`define RPD_ADR_PM_TS    10'h00b
`define RPD_ADR_PM_SEG   10'h00c
`define RPD_ADR_CONV     10'h028
`define RPD_ADR_DDC0     10'h02c
`define RPD_ADR_RDC0     10'h034
`define RPD_ADR_RDC8     10'h03c

// ****************************************************************
// reset values
// ****************************************************************
`define RPD_RST_NIB      4'h0
`define RPD_RST_LATCH    4'hf

// ****************************************************************
// pin positions of multiplexed functions
// ****************************************************************
`define RPD_PIN_EVB      4
`define RPD_PIN_EVD      5
`define RPD_PIN_BUZ      6
`define RPD_PIN_TOB      7
`define RPD_PIN_TOC      8
`define RPD_PIN_SCK      9
`define RPD_PIN_SIO      10
`define RPD_PIN_SEG      12
`define RPD_PIN_AN       28
`define RPD_PIN_LAST     33

`endif

/* design/rpd_pin_cell.v */
// Purpose : one r pin, chooses port latch or peripheral function
// Assumes : all inputs on the system clock
// Notes   : combinational, the top registers the result
`timescale 1ns/100ps

module rpd_pin_cell
(
    input  wire latch_val,
    input  wire drive_en,
    input  wire func_sel,
    input  wire func_dat,
    input  wire func_oe,
    output wire pin_out,
    output wire pin_oe
);

    // ************************************************************
    // selection
    // ************************************************************
    // peripheral owns the pin when selected
    assign pin_out = func_sel ? func_dat : latch_val;
    // with no function selected, drive bit 1 turns the buffer on, 0 leaves it floating
    assign pin_oe  = func_sel ? func_oe : drive_en;

endmodule // rpd_pin_cell

/* design/rpd_port.v */
// Purpose : r port drive control and pin function select
// Assumes : single system clock, asynchronous active high reset
// Notes   : mode and drive registers are write only
`timescale 1ns/100ps
`include "rpd_defs.vh"

module rpd_port
#(
    parameter GROUPS = `RPD_GROUPS
)
(
    input  wire                     clock,
    input  wire                     reset,
    input  wire                     mem_we,
    input  wire [`RPD_ADDR_W-1:0]   mem_addr,
    input  wire [`RPD_DATA_W-1:0]   mem_wdata,
    input  wire                     port_rd,
    input  wire                     port_wr,
    input  wire [`RPD_GRP_W-1:0]    port_grp,
    input  wire [`RPD_DATA_W-1:0]   port_wdata,
    output reg  [`RPD_DATA_W-1:0]   port_rdata_r,
    output reg                      port_rvalid_r,
    input  wire [`RPD_PINS-1:0]     r_pin_in,
    output reg  [`RPD_PINS-1:0]     r_pin_out_r,
    output reg  [`RPD_PINS-1:0]     r_pin_oe_r,
    output reg  [`RPD_D_PINS-1:0]   d_group_drive_enable_r,
    output reg  [`RPD_DATA_W-1:0]   port_mode_0_r,
    output reg  [3:0]               wake_input_n_r,
    output reg                      event_input_b_r,
    output reg                      event_input_d_r,
    input  wire                     buzzer_out,
    input  wire                     timer_b_output,
    input  wire                     timer_c_output,
    input  wire                     serial_clk_out_n,
    input  wire                     serial_clk_drive,
    output reg                      serial_clk_in_n_r,
    input  wire                     serial_data_out,
    output reg                      serial_data_in_r,
    input  wire [15:0]              lcd_segment_first,
    output reg  [`RPD_AN_PINS-1:0]  analog_input_sel_r
);

    // ************************************************************
    // declarations
    // ************************************************************
    reg  [`RPD_PINS-1:0]     r_group_drive_enable_r;
    reg  [`RPD_PINS-1:0]     pin_output_latch_r;
    reg  [`RPD_DATA_W-1:0]   wakeup_select_reg_r;
    reg  [`RPD_DATA_W-1:0]   event_timer_select_reg_r;
    reg  [`RPD_DATA_W-1:0]   timer_serial_select_reg_r;
    reg  [`RPD_DATA_W-1:0]   segment_select_reg_r;
    reg  [`RPD_DATA_W-1:0]   converter_mode_reg_r;
    reg  [`RPD_PINS-1:0]     sync1_r;
    reg  [`RPD_PINS-1:0]     sync2_r;
    reg  [`RPD_PINS-1:0]     func_sel;
    reg  [`RPD_PINS-1:0]     func_dat;
    reg  [`RPD_PINS-1:0]     func_oe;
    wire [`RPD_PINS-1:0]     pin_out_nxt;
    wire [`RPD_PINS-1:0]     pin_oe_nxt;
    wire [`RPD_PINS-1:0]     pin_exists;
    wire [2:0]               an_count;
    wire                     grp_ok;
    wire [5:0]               grp_base;
    wire [`RPD_DATA_W-1:0]   grp_level;
    integer                  i;

    // ************************************************************
    // pin input synchroniser
    // ************************************************************
    always @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            sync1_r <= {`RPD_PINS{1'b0}};
            sync2_r <= {`RPD_PINS{1'b0}};
        end
        else
        begin
            sync1_r <= r_pin_in;
            sync2_r <= sync1_r;
        end
    end

    // ************************************************************
    // mode registers
    // ************************************************************
    always @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            port_mode_0_r             <= `RPD_RST_NIB;
            wakeup_select_reg_r       <= `RPD_RST_NIB;
            event_timer_select_reg_r  <= `RPD_RST_NIB;
            timer_serial_select_reg_r <= `RPD_RST_NIB;
            segment_select_reg_r      <= `RPD_RST_NIB;
            converter_mode_reg_r      <= `RPD_RST_NIB;
        end
        else if (mem_we)
        begin
            case (mem_addr)
                `RPD_ADR_PM0:
                    port_mode_0_r <= mem_wdata;
                `RPD_ADR_PM_WAKE:
                    wakeup_select_reg_r <= mem_wdata;
                `RPD_ADR_PM_EVT:
                    event_timer_select_reg_r <= mem_wdata;
                `RPD_ADR_PM_TS:
                    timer_serial_select_reg_r <= mem_wdata;
                `RPD_ADR_PM_SEG:
                    segment_select_reg_r <= mem_wdata;
                `RPD_ADR_CONV:
                    converter_mode_reg_r <= mem_wdata;
                default:
                    converter_mode_reg_r <= converter_mode_reg_r;
            endcase
        end
    end

    // ************************************************************
    // per group drive registers and output latches
    // ************************************************************
    genvar g;
    generate
        for (g = 0; g < GROUPS; g = g + 1)
        begin : grp
            localparam [31:0] ADR_FULL = `RPD_ADR_RDC0 + g;
            localparam [`RPD_ADDR_W-1:0] ADR = ADR_FULL[`RPD_ADDR_W-1:0];
            localparam [31:0] GID_FULL = g;
            localparam [`RPD_GRP_W-1:0] GID = GID_FULL[`RPD_GRP_W-1:0];
            always @(posedge clock or posedge reset)
            begin
                if (reset)
                begin
                    r_group_drive_enable_r[4*g+3:4*g] <= `RPD_RST_NIB;
                    pin_output_latch_r[4*g+3:4*g]     <= `RPD_RST_LATCH;
                end
                else
                begin
                    if (mem_we && mem_addr == ADR)
                        r_group_drive_enable_r[4*g+3:4*g] <= mem_wdata;
                    if (port_wr && port_grp == GID)
                        pin_output_latch_r[4*g+3:4*g] <= port_wdata;
                end
            end
        end
        for (g = GROUPS*4; g < `RPD_PINS; g = g + 1)
        begin : pad
            always @(posedge clock or posedge reset)
            begin
                if (reset)
                begin
                    r_group_drive_enable_r[g] <= 1'b0;
                    pin_output_latch_r[g]     <= 1'b0;
                end
                else
                begin
                    r_group_drive_enable_r[g] <= 1'b0;
                    pin_output_latch_r[g]     <= 1'b0;
                end
            end
        end
    endgenerate

    // ************************************************************
    // d port drive registers
    // ************************************************************
    always @(posedge clock or posedge reset)
    begin
        if (reset)
            d_group_drive_enable_r <= {`RPD_D_PINS{1'b0}};
        else if (mem_we)
        begin
            case (mem_addr)
                `RPD_ADR_DDC0:
                    d_group_drive_enable_r[3:0] <= mem_wdata;
                `RPD_ADR_DDC0 + 10'h001:
                    d_group_drive_enable_r[7:4] <= mem_wdata;
                `RPD_ADR_DDC0 + 10'h002:
                    d_group_drive_enable_r[11:8] <= mem_wdata;
                default:
                    d_group_drive_enable_r <= d_group_drive_enable_r;
            endcase
        end
    end

    // ************************************************************
    // function select per pin
    // ************************************************************
    assign an_count = (converter_mode_reg_r[3:1] > 3'h6) ?
                      3'h6 : converter_mode_reg_r[3:1];

    always @*
    begin
        func_sel = {`RPD_PINS{1'b0}};
        func_dat = {`RPD_PINS{1'b0}};
        func_oe  = {`RPD_PINS{1'b0}};
        for (i = 0; i < 4; i = i + 1)
            func_sel[i] = wakeup_select_reg_r[i];
        func_sel[`RPD_PIN_EVB] = event_timer_select_reg_r[0];
        func_sel[`RPD_PIN_EVD] = event_timer_select_reg_r[1];
        func_sel[`RPD_PIN_BUZ] = event_timer_select_reg_r[2];
        func_dat[`RPD_PIN_BUZ] = buzzer_out;
        func_oe[`RPD_PIN_BUZ]  = 1'b1;
        func_sel[`RPD_PIN_TOB] = event_timer_select_reg_r[3];
        func_dat[`RPD_PIN_TOB] = timer_b_output;
        func_oe[`RPD_PIN_TOB]  = 1'b1;
        func_sel[`RPD_PIN_TOC] = timer_serial_select_reg_r[0];
        func_dat[`RPD_PIN_TOC] = timer_c_output;
        func_oe[`RPD_PIN_TOC]  = 1'b1;
        func_sel[`RPD_PIN_SCK] = timer_serial_select_reg_r[1];
        func_dat[`RPD_PIN_SCK] = serial_clk_out_n;
        func_oe[`RPD_PIN_SCK]  = serial_clk_drive;
        func_sel[`RPD_PIN_SIO] = timer_serial_select_reg_r[2] |
                                 timer_serial_select_reg_r[3];
        func_dat[`RPD_PIN_SIO] = serial_data_out;
        func_oe[`RPD_PIN_SIO]  = timer_serial_select_reg_r[3];
        for (i = 0; i < 16; i = i + 1)
        begin
            func_sel[`RPD_PIN_SEG+i] = segment_select_reg_r[i/4];
            func_dat[`RPD_PIN_SEG+i] = lcd_segment_first[i];
            func_oe[`RPD_PIN_SEG+i]  = segment_select_reg_r[i/4];
        end
        for (i = 0; i < `RPD_AN_PINS; i = i + 1)
            func_sel[`RPD_PIN_AN+i] = (an_count > i);
    end

    // ************************************************************
    // pin cells
    // ************************************************************
    generate
        for (g = 0; g < `RPD_PINS; g = g + 1)
        begin : pin
            assign pin_exists[g] = (g <= `RPD_PIN_LAST);
            rpd_pin_cell u_cell
            (
                .latch_val (pin_output_latch_r[g]),
                .drive_en  (r_group_drive_enable_r[g]),
                .func_sel  (func_sel[g]),
                .func_dat  (func_dat[g]),
                .func_oe   (func_oe[g]),
                .pin_out   (pin_out_nxt[g]),
                .pin_oe    (pin_oe_nxt[g])
            );
        end
    endgenerate

    always @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            r_pin_out_r <= {`RPD_PINS{1'b0}};
            r_pin_oe_r  <= {`RPD_PINS{1'b0}};
        end
        else
        begin
            r_pin_out_r <= pin_out_nxt & pin_exists;
            r_pin_oe_r  <= pin_oe_nxt & pin_exists;
        end
    end

    // ************************************************************
    // port read
    // ************************************************************
    assign grp_ok    = (port_grp < GROUPS);
    assign grp_base  = {port_grp, 2'b00};
    assign grp_level = grp_ok ? sync2_r[grp_base +: 4] : `RPD_RST_NIB;

    always @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            port_rdata_r  <= `RPD_RST_NIB;
            port_rvalid_r <= 1'b0;
        end
        else
        begin
            port_rvalid_r <= port_rd;
            if (port_rd)
                port_rdata_r <= grp_level;
        end
    end

    // ************************************************************
    // peripheral inputs
    // ************************************************************
    always @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            wake_input_n_r     <= 4'hf;
            event_input_b_r    <= 1'b0;
            event_input_d_r    <= 1'b0;
            serial_clk_in_n_r  <= 1'b1;
            serial_data_in_r   <= 1'b0;
            analog_input_sel_r <= {`RPD_AN_PINS{1'b0}};
        end
        else
        begin
            wake_input_n_r <= sync2_r[3:0] |
                              ~wakeup_select_reg_r;
            event_input_b_r <= sync2_r[`RPD_PIN_EVB] &
                               event_timer_select_reg_r[0];
            event_input_d_r <= sync2_r[`RPD_PIN_EVD] &
                               event_timer_select_reg_r[1];
            serial_clk_in_n_r <= sync2_r[`RPD_PIN_SCK] |
                                 ~timer_serial_select_reg_r[1];
            serial_data_in_r <= sync2_r[`RPD_PIN_SIO] &
                                timer_serial_select_reg_r[2];
            analog_input_sel_r <=
                func_sel[`RPD_PIN_AN+`RPD_AN_PINS-1:`RPD_PIN_AN];
        end
    end

endmodule // rpd_port

/* verif/rpd_port_properties.sv */
// Purpose : concurrent checks on the r port block ports
// Assumes : one clock, asynchronous active high reset
// Notes   : bound to rpd_port after the module
`timescale 1ns/100ps

module rpd_port_properties
#(
    parameter GROUPS = 9
)
(
    input wire        clock,
    input wire        reset,
    input wire        mem_we,
    input wire [9:0]  mem_addr,
    input wire [3:0]  mem_wdata,
    input wire        port_rd,
    input wire        port_wr,
    input wire [3:0]  port_grp,
    input wire [3:0]  port_wdata,
    input wire [3:0]  port_rdata_r,
    input wire        port_rvalid_r,
    input wire [35:0] r_pin_out_r,
    input wire [35:0] r_pin_oe_r,
    input wire [11:0] d_group_drive_enable_r,
    input wire [15:0] lcd_segment_first,
    input wire [5:0]  analog_input_sel_r
);
    // ****
    // segment select shadow for group 3
    // ****
    reg seg_r;

    always @(posedge clock or posedge reset)
    begin
        if (reset)
            seg_r <= 1'b0;
        else if (mem_we && mem_addr == 10'h00c)
            seg_r <= mem_wdata[0];
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    // ****
    // assertions
    // ****
    chk_rvalid_after_read: assert property (
        port_rd |=> port_rvalid_r) else $error("read gave no valid");
    chk_no_stray_valid: assert property (
        !port_rd |=> !port_rvalid_r) else $error("valid without read");
    chk_bad_group_zero: assert property (
        port_rd && port_grp >= 4'h9 |=> port_rdata_r == 4'h0)
        else $error("bad group read not zero");
    chk_rdata_holds: assert property (
        !port_rd |=> $stable(port_rdata_r)) else $error("rdata moved");
    chk_top_pins_float: assert property (
        r_pin_oe_r[35:34] == 2'b00) else $error("pins 34,35 driven");
    chk_drive_group4: assert property (
        mem_we && mem_addr == 10'h038 && mem_wdata == 4'hf
        ##1 !(mem_we && mem_addr == 10'h038) |=> r_pin_oe_r[19:16] == 4'hf)
        else $error("group 4 drive not on");
    chk_d_drive_map: assert property (
        mem_we && mem_addr == 10'h02d ##1 !(mem_we && mem_addr == 10'h02d)
        |=> d_group_drive_enable_r[7:4] == $past(mem_wdata, 2))
        else $error("d drive 4-7 wrong");
    chk_latch_write: assert property (
        port_wr && port_grp == 4'h3 && !seg_r ##1 !port_wr && !seg_r
        |=> r_pin_out_r[15:12] == $past(port_wdata, 2))
        else $error("group 3 latch wrong");
    chk_analog_floats: assert property (
        analog_input_sel_r[0] |-> !r_pin_oe_r[28])
        else $error("analog pin driven");
    chk_segment_drive: assert property (
        seg_r ##1 seg_r |=> r_pin_oe_r[15:12] == 4'hf
        && r_pin_out_r[15:12] == $past(lcd_segment_first[3:0]))
        else $error("segment group 3 wrong");

    cov_read: cover property (port_rd ##1 port_rvalid_r);
    cov_segment: cover property (seg_r ##2 seg_r);
    cov_analog: cover property (analog_input_sel_r == 6'h3f);
endmodule // rpd_port_properties

bind rpd_port rpd_port_properties #(.GROUPS(GROUPS)) u_props (
    .clock(clock), .reset(reset), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .port_rd(port_rd), .port_wr(port_wr),
    .port_grp(port_grp), .port_wdata(port_wdata),
    .port_rdata_r(port_rdata_r), .port_rvalid_r(port_rvalid_r),
    .r_pin_out_r(r_pin_out_r), .r_pin_oe_r(r_pin_oe_r),
    .d_group_drive_enable_r(d_group_drive_enable_r),
    .lcd_segment_first(lcd_segment_first),
    .analog_input_sel_r(analog_input_sel_r));

/* verif/rpd_port_test.sv */
// Purpose : self-checking bench for the r port block
// Assumes : 20 MHz clock, reset held 6 cycles
// Notes   : each scenario is a task
`timescale 1ns/100ps

module rpd_port_test;
    reg          clock;
    reg          reset;
    reg          mem_we;
    reg  [9:0]   mem_addr;
    reg  [3:0]   mem_wdata;
    reg          port_rd;
    reg          port_wr;
    reg  [3:0]   port_grp;
    reg  [3:0]   port_wdata;
    reg  [35:0]  r_pin_in;
    reg          tmr;
    reg          sck_n;
    reg          sck_drv;
    reg          sdo;
    reg  [15:0]  lcd;
    wire [3:0]   rdata;
    wire         rvalid;
    wire [35:0]  pout;
    wire [35:0]  poe;
    wire [11:0]  d_en;
    wire [3:0]   pm0;
    wire [3:0]   wake_n;
    wire         evb;
    wire         evd;
    wire         sck_in_n;
    wire         sdi;
    wire [5:0]   an_sel;
    int          fail_count;
    int          n_tests;
    logic [35:0] exp_v;

    rpd_port dut (.clock(clock), .reset(reset), .mem_we(mem_we),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .port_rd(port_rd),
        .port_wr(port_wr), .port_grp(port_grp), .port_wdata(port_wdata),
        .port_rdata_r(rdata), .port_rvalid_r(rvalid), .r_pin_in(r_pin_in),
        .r_pin_out_r(pout), .r_pin_oe_r(poe), .d_group_drive_enable_r(d_en),
        .port_mode_0_r(pm0), .wake_input_n_r(wake_n),
        .event_input_b_r(evb), .event_input_d_r(evd), .buzzer_out(tmr),
        .timer_b_output(tmr), .timer_c_output(tmr),
        .serial_clk_out_n(sck_n), .serial_clk_drive(sck_drv),
        .serial_clk_in_n_r(sck_in_n), .serial_data_out(sdo),
        .serial_data_in_r(sdi), .lcd_segment_first(lcd),
        .analog_input_sel_r(an_sel));

    task chk(input string nm, input logic [35:0] e, input logic [35:0] g);
        n_tests++;
        if (g !== e)
        begin
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
            fail_count++;
        end
    endtask

    task end_of_test;
        if (fail_count == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task reg_wr(input logic [9:0] a, input logic [3:0] d);
        @(posedge clock);
        mem_we <= 1'b1;
        mem_addr <= a;
        mem_wdata <= d;
        @(posedge clock);
        mem_we <= 1'b0;
        repeat (3) @(posedge clock);
        #1;
    endtask

    task grp_wr(input logic [3:0] g, input logic [3:0] d);
        @(posedge clock);
        port_wr <= 1'b1;
        port_grp <= g;
        port_wdata <= d;
        @(posedge clock);
        port_wr <= 1'b0;
        @(posedge clock);
        #1;
    endtask

    task grp_rd(input logic [3:0] g, input logic [3:0] e);
        @(posedge clock);
        port_rd <= 1'b1;
        port_grp <= g;
        @(posedge clock);
        port_rd <= 1'b0;
        #1;
        chk("rvalid", 1, rvalid);
        chk("rdata", e, rdata);
        @(posedge clock);
        #1;
        chk("rvalid low", 0, rvalid);
    endtask

    // ****
    // scenarios
    // ****
    task t_reset_state;
        chk("out", 36'h3_ffff_ffff, pout[33:0]);
        chk("oe", 0, poe);
        chk("d_en", 0, d_en);
        chk("wake_n", 4'hf, wake_n);
    endtask

    task t_port_io;
        grp_wr(4'h1, 4'h5);
        grp_wr(4'h3, 4'h6);
        grp_wr(4'h9, 4'h0);
        chk("out", 36'h3_ffff_6f5f, pout[33:0]);
        grp_rd(4'h2, 4'ha);
        grp_rd(4'h8, 4'h3);
        grp_rd(4'h9, 4'h0);
    endtask

    task t_drive;
        exp_v = 0;
        for (int g = 0; g < 9; g++)
        begin
            exp_v[4*g +: 4] = g[0] ? 4'ha : 4'h5;
            reg_wr(10'h034 + g, exp_v[4*g +: 4]);
        end
        exp_v[35:34] = 2'b00;
        chk("oe", exp_v, poe);
        reg_wr(10'h03d, 4'hf);
        chk("oe unmapped", exp_v, poe);
        reg_wr(10'h02c, 4'h1);
        reg_wr(10'h02d, 4'h2);
        reg_wr(10'h02e, 4'h4);
        chk("d_en", 12'h421, d_en);
        reg_wr(10'h008, 4'ha);
        chk("pm0", 4'ha, pm0);
        reg_wr(10'h038, 4'hf);
        chk("oe grp4", 4'hf, poe[19:16]);
    endtask

    task t_functions;
        @(posedge clock);
        r_pin_in <= 36'h3_0000_0a16;
        reg_wr(10'h009, 4'hf);
        reg_wr(10'h00a, 4'h3);
        chk("wake_n", 4'h6, wake_n);
        chk("evb evd", 2'b01, {evd, evb});
        chk("oe 5:0", 0, poe[5:0]);
        reg_wr(10'h00a, 4'hf);
        reg_wr(10'h00b, 4'h1);
        chk("out 8:6", 0, pout[8:6]);
        chk("oe 8:6", 3'h7, poe[8:6]);
        @(posedge clock);
        r_pin_in <= 36'h3_0000_0416;
        reg_wr(10'h00b, 4'h7);
        chk("sck sdi", 2'b10, {sdi, sck_in_n});
        @(posedge clock);
        sck_drv <= 1'b1;
        sck_n <= 1'b0;
        sdo <= 1'b0;
        reg_wr(10'h00b, 4'hf);
        chk("out 10:9", 0, pout[10:9]);
        chk("oe 10:9", 2'h3, poe[10:9]);
        reg_wr(10'h00c, 4'hf);
        chk("seg out", 16'h5a3c, pout[27:12]);
        chk("seg oe", 16'hffff, poe[27:12]);
        reg_wr(10'h028, 4'hc);
        chk("an 6", 6'h3f, an_sel);
        chk("an oe", 0, poe[33:28]);
        reg_wr(10'h028, 4'h4);
        chk("an 2", 6'h03, an_sel);
    endtask

    task t_reset_again;
        @(posedge clock);
        reset <= 1'b1;
        @(posedge clock);
        #1;
        chk("oe rst", 0, poe);
        chk("d_en rst", 0, d_en);
        @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        #1;
        chk("out rst", 36'h3_ffff_ffff, pout[33:0]);
        chk("oe after rst", 0, poe);
    endtask

    initial
    begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    initial
    begin
        repeat (2000) @(posedge clock);
        fail_count++;
        end_of_test;
    end

    initial
    begin
        reset = 1'b1;
        mem_we = 1'b0;
        mem_addr = 10'h000;
        mem_wdata = 4'h0;
        port_rd = 1'b0;
        port_wr = 1'b0;
        port_grp = 4'h0;
        port_wdata = 4'h0;
        r_pin_in = 36'h3_0000_0a00;
        tmr = 1'b0;
        sck_n = 1'b1;
        sck_drv = 1'b0;
        sdo = 1'b1;
        lcd = 16'h5a3c;
        fail_count = 0;
        n_tests = 0;
        repeat (6) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        #1;
        t_reset_state;
        t_port_io;
        t_drive;
        t_functions;
        t_reset_again;
        end_of_test;
    end
endmodule // rpd_port_test
